//--- hdl/gdsr_regs.sv
// Status and control register bank of the H-bridge gate driver.
`timescale 1ns/1ps
// How it works
// - Status registers ignore writes
// - Summary bit 7 ORs bits 6..1
// - Summary bit 5 is any gate fault
// - Summary bit 4 is overcurrent fault
// - Summary bit 3 is supply undervoltage
// - Summary bit 2 is pump undervoltage
// - Bits 6,1,0: watchdog, shutdown, warning
// - FET bits 7..4: gate faults per FET
// - FET bits 3..0: overcurrent per FET
// - Control registers 2..5 read and write
// - Frame: rw bit15, addr 14..11, data 7..0
// - Fault clear bit clears status bits
module gdsr_regs
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Received frame, one-cycle strobe with the whole word
  input  wire logic                  i_frame_valid,
  input  wire logic [15:0]           i_frame,
  // Fault conditions from the detectors
  input  wire gdsr_pkg::gdsr_fault_in_s i_faults,
  // Response byte for the frame just taken
  output logic                       o_rdata_valid,
  output logic [7:0]                 o_rdata,
  // Control register contents for the rest of the device
  output logic [7:0]                 o_main_control,
  output logic [7:0]                 o_drive_strength_watchdog_control,
  output logic [7:0]                 o_overcurrent_monitor_control,
  output logic [7:0]                 o_chopper_amp_config,
  // Summary fault level
  output logic                       o_fault
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic                  rst_n;        // Synchronised reset.
  gdsr_pkg::gdsr_req_s   req;          // Decoded frame.
  logic [7:0]            fault_summary_status; // Stored bits 6..0; bit 7 rebuilt.
  logic [7:0]            fet_fault_status;     // Per-FET sticky flags.
  logic [7:0]            ctrl [gdsr_pkg::NUM_CTRL_REGS]; // Control registers 2..5.
  logic [7:0]            summary_view; // Summary with the OR bit filled in.
  logic                  clear_req;    // Host asks for a fault clear.
  logic [7:0]            next_summary; // Summary update.
  logic [7:0]            next_fet;     // FET status update.

  // Reads a register by address; unmapped offsets answer zero.
  function automatic logic [7:0] read_mux(input logic [3:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      gdsr_pkg::ADDR_FAULT_SUMMARY: r = summary_view;
      gdsr_pkg::ADDR_FET_FAULT:     r = fet_fault_status;
      gdsr_pkg::ADDR_MAIN_CTRL:     r = ctrl[0];
      gdsr_pkg::ADDR_DRIVE_WD_CTRL: r = ctrl[1];
      gdsr_pkg::ADDR_OC_MON_CTRL:   r = ctrl[2];
      gdsr_pkg::ADDR_CHOP_CFG:      r = ctrl[3];
      default:                      r = 8'h00;
    endcase
    return r;
  endfunction

  gdsr_reset_sync u_rst
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .o_resetn (rst_n)
  );

  // ********************************************************************
  // Frame decode
  // ********************************************************************
  // Field slicing of the 16-bit word; bits 10..8 are don't care.
  always_comb
  begin
    req.valid = i_frame_valid;
    req.read  = i_frame[gdsr_pkg::FRAME_RW_BIT];
    req.addr  = i_frame[gdsr_pkg::FRAME_ADDR_HI:gdsr_pkg::FRAME_ADDR_LO];
    req.wdata = i_frame[gdsr_pkg::FRAME_DATA_HI:0];
  end

  // A write of 1 to the clear bit of main control.
  assign clear_req = req.valid && !req.read && (req.addr == gdsr_pkg::ADDR_MAIN_CTRL)
                     && req.wdata[gdsr_pkg::MAIN_FAULT_CLEAR];

  // ********************************************************************
  // Sticky fault status
  // ********************************************************************
  // New events are ORed in after the clear so a same-cycle event is kept.
  always_comb
  begin
    next_summary = clear_req ? 8'h00 : fault_summary_status;
    next_fet     = clear_req ? 8'h00 : fet_fault_status;
    next_fet[7:4] = next_fet[7:4] | i_faults.fet_gate_fault;
    next_fet[3:0] = next_fet[3:0] | i_faults.fet_overcurrent;
    next_summary[gdsr_pkg::FS_WATCHDOG]    |= i_faults.watchdog_timeout_flag;
    next_summary[gdsr_pkg::FS_GATE_DRIVE]  |= |i_faults.fet_gate_fault;
    next_summary[gdsr_pkg::FS_OVERCURRENT] |= |i_faults.fet_overcurrent;
    next_summary[gdsr_pkg::FS_SUPPLY_UV]   |= i_faults.supply_undervoltage_flag;
    next_summary[gdsr_pkg::FS_PUMP_UV]     |= i_faults.pump_undervoltage_flag;
    next_summary[gdsr_pkg::FS_OT_SHUTDOWN] |= i_faults.overtemp_shutdown_flag;
    next_summary[gdsr_pkg::FS_OT_WARNING]  |= i_faults.overtemp_warning_flag;
    next_summary[gdsr_pkg::FS_FAULT_ANY]   = 1'b0;
  end

  // Status bits only follow the detectors and the clear; frames never write them.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_summary_status <= gdsr_pkg::RST_STATUS;
      fet_fault_status     <= gdsr_pkg::RST_STATUS;
    end
    else
    begin
      fault_summary_status <= next_summary;
      fet_fault_status     <= next_fet;
    end
  end

  // The summary OR excludes the warning bit, so a warning alone is no fault.
  always_comb
  begin
    summary_view = fault_summary_status;
    summary_view[gdsr_pkg::FS_FAULT_ANY] =
      |fault_summary_status[gdsr_pkg::FS_WATCHDOG:gdsr_pkg::FS_OT_SHUTDOWN];
  end

  // ********************************************************************
  // Control registers
  // ********************************************************************
  // Offsets 2..5 store the written byte; the clear bit is held as written, as
  // the register map shows it readable. Reserved offsets are not stored.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl[0] <= gdsr_pkg::RST_MAIN_CTRL;
      ctrl[1] <= gdsr_pkg::RST_DRIVE_WD;
      ctrl[2] <= gdsr_pkg::RST_OC_MON;
      ctrl[3] <= gdsr_pkg::RST_CHOP_CFG;
    end
    else if (req.valid && !req.read && req.addr >= gdsr_pkg::ADDR_MAIN_CTRL
             && req.addr <= gdsr_pkg::ADDR_CHOP_CFG)
    begin
      ctrl[2'(req.addr - gdsr_pkg::ADDR_MAIN_CTRL)] <= req.wdata;
    end
  end

  // ********************************************************************
  // Response and outputs
  // ********************************************************************
  // Both reads and writes return the content before this frame's write.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rdata_valid <= 1'b0;
      o_rdata       <= 8'h00;
    end
    else
    begin
      o_rdata_valid <= req.valid;
      if (req.valid)
      begin
        o_rdata <= read_mux(req.addr);
      end
    end
  end

  // Registered copies for the rest of the device; one cycle behind the store.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_main_control                    <= gdsr_pkg::RST_MAIN_CTRL;
      o_drive_strength_watchdog_control <= gdsr_pkg::RST_DRIVE_WD;
      o_overcurrent_monitor_control     <= gdsr_pkg::RST_OC_MON;
      o_chopper_amp_config              <= gdsr_pkg::RST_CHOP_CFG;
      o_fault                           <= 1'b0;
    end
    else
    begin
      o_main_control                    <= ctrl[0];
      o_drive_strength_watchdog_control <= ctrl[1];
      o_overcurrent_monitor_control     <= ctrl[2];
      o_chopper_amp_config              <= ctrl[3];
      o_fault                           <= summary_view[gdsr_pkg::FS_FAULT_ANY];
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  property p_status_ro;
    @(posedge i_clk) disable iff (!rst_n)
    (req.valid && !req.read && req.addr == gdsr_pkg::ADDR_FET_FAULT && !clear_req
     && i_faults.fet_gate_fault == 4'h0 && i_faults.fet_overcurrent == 4'h0)
    |=> fet_fault_status == $past(fet_fault_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  // The pin level must follow the stored bits 6..1 one cycle later, warning excluded.
  property p_fault_or;
    @(posedge i_clk) disable iff (!rst_n)
    o_fault == (|$past(fault_summary_status[6:1]));
  endproperty
  a_fault_or: assert property (p_fault_or) else $error("summary OR wrong");

  property p_gate_summary;
    @(posedge i_clk) disable iff (!rst_n)
    (|i_faults.fet_gate_fault) |=> fault_summary_status[5] && (|fet_fault_status[7:4]);
  endproperty
  a_gate_summary: assert property (p_gate_summary) else $error("gate fault lost");

  property p_oc_summary;
    @(posedge i_clk) disable iff (!rst_n)
    (|i_faults.fet_overcurrent) |=> fault_summary_status[4];
  endproperty
  a_oc_summary: assert property (p_oc_summary) else $error("overcurrent lost");

  property p_uv;
    @(posedge i_clk) disable iff (!rst_n)
    i_faults.supply_undervoltage_flag |=> fault_summary_status[3];
  endproperty
  a_uv: assert property (p_uv) else $error("supply undervoltage lost");

  property p_pump;
    @(posedge i_clk) disable iff (!rst_n)
    i_faults.pump_undervoltage_flag |=> fault_summary_status[2];
  endproperty
  a_pump: assert property (p_pump) else $error("pump undervoltage lost");

  property p_warn_only;
    @(posedge i_clk) disable iff (!rst_n)
    (fault_summary_status[6:1] == 6'h00) |-> !summary_view[7];
  endproperty
  a_warn_only: assert property (p_warn_only) else $error("warning set summary");

  property p_clear;
    @(posedge i_clk) disable iff (!rst_n)
    (clear_req && i_faults == '0) |=> fault_summary_status == 8'h00 && fet_fault_status == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_sticky;
    @(posedge i_clk) disable iff (!rst_n)
    (fet_fault_status[0] && !clear_req) |=> fet_fault_status[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault bit dropped");

  property p_readback;
    @(posedge i_clk) disable iff (!rst_n)
    (req.valid && !req.read && req.addr == gdsr_pkg::ADDR_CHOP_CFG) ##1 !req.valid ##1
    (req.valid && req.read && req.addr == gdsr_pkg::ADDR_CHOP_CFG)
    |=> o_rdata_valid && o_rdata == $past(req.wdata, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("control readback wrong");

  c_clear: cover property (@(posedge i_clk) disable iff (!rst_n) clear_req);
  c_read_status: cover property (@(posedge i_clk) disable iff (!rst_n)
    req.valid && req.read && req.addr == gdsr_pkg::ADDR_FAULT_SUMMARY && summary_view[7]);
  c_write_ctrl: cover property (@(posedge i_clk) disable iff (!rst_n)
    req.valid && !req.read && req.addr == gdsr_pkg::ADDR_DRIVE_WD_CTRL);

endmodule

//--- hdl/gdsr_pkg.sv
// Package with register map, field layout, frame format and carrier types of the status bank.
package gdsr_pkg;

  // ********************************************************************
  // Register offsets (4-bit address field of the frame)
  // ********************************************************************
  localparam logic [3:0] ADDR_FAULT_SUMMARY = 4'h0; // Fault summary status, read only.
  localparam logic [3:0] ADDR_FET_FAULT     = 4'h1; // Per-FET fault status, read only.
  localparam logic [3:0] ADDR_MAIN_CTRL     = 4'h2; // Main control.
  localparam logic [3:0] ADDR_DRIVE_WD_CTRL = 4'h3; // Drive strength and watchdog control.
  localparam logic [3:0] ADDR_OC_MON_CTRL   = 4'h4; // Overcurrent monitor control.
  localparam logic [3:0] ADDR_CHOP_CFG      = 4'h5; // Chopper and amplifier configuration.
  localparam int         NUM_CTRL_REGS      = 4;    // Number of read/write control registers.

  // ********************************************************************
  // Frame layout
  // ********************************************************************
  localparam int FRAME_RW_BIT  = 15; // 1 = read, 0 = write.
  localparam int FRAME_ADDR_HI = 14; // Address field top bit.
  localparam int FRAME_ADDR_LO = 11; // Address field bottom bit.
  localparam int FRAME_DATA_HI = 7;  // Data field top bit.

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int FS_FAULT_ANY   = 7; // Summary: OR of bits 6..1.
  localparam int FS_WATCHDOG    = 6;
  localparam int FS_GATE_DRIVE  = 5;
  localparam int FS_OVERCURRENT = 4;
  localparam int FS_SUPPLY_UV   = 3;
  localparam int FS_PUMP_UV     = 2;
  localparam int FS_OT_SHUTDOWN = 1;
  localparam int FS_OT_WARNING  = 0;
  localparam int MAIN_FAULT_CLEAR = 0; // Fault clear bit of main control.

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] RST_STATUS     = 8'h00;
  localparam logic [7:0] RST_MAIN_CTRL  = 8'h18; // Lock field 011b, rest zero.
  localparam logic [7:0] RST_DRIVE_WD   = 8'h07; // Drive strength 111b.
  localparam logic [7:0] RST_OC_MON     = 8'h00;
  localparam logic [7:0] RST_CHOP_CFG   = 8'h00;

  // Fault condition inputs from the detection circuits, one level each.
  typedef struct packed {
    logic       watchdog_timeout_flag;
    logic       supply_undervoltage_flag;
    logic       pump_undervoltage_flag;
    logic       overtemp_shutdown_flag;
    logic       overtemp_warning_flag;
    logic [3:0] fet_gate_fault;   // hb2 high, hb2 low, hb1 high, hb1 low.
    logic [3:0] fet_overcurrent;  // Same order.
  } gdsr_fault_in_s;

  // One decoded register access.
  typedef struct packed {
    logic       valid;
    logic       read;
    logic [3:0] addr;
    logic [7:0] wdata;
  } gdsr_req_s;

endpackage

//--- hdl/gdsr_reset_sync.sv
// Two-stage reset release synchroniser.
`timescale 1ns/1ps
module gdsr_reset_sync
(
  // Clock and raw reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Synchronised reset
  output logic      o_resetn
);

  // First stage; only the second stage reads it.
  logic meta_resetn;

  // ********************************************************************
  // Release
  // ********************************************************************
  // Assertion is asynchronous, release is aligned to the clock.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_resetn <= 1'b0;
      o_resetn    <= 1'b0;
    end
    else
    begin
      meta_resetn <= 1'b1;
      o_resetn    <= meta_resetn;
    end
  end

endmodule

//--- test/gdsr_host_model.sv
// Host model that sends whole register frames to the status bank and collects answers.
`timescale 1ns/1ps
module gdsr_host_model
(
  // Clock
  input  wire logic        i_clk,
  // Answer from the bank
  input  wire logic        i_rdata_valid,
  input  wire logic [7:0]  i_rdata,
  // Frame towards the bank
  output logic             o_frame_valid,
  output logic [15:0]      o_frame
);
  // ********************************************************************
  // Frame driver
  // ********************************************************************
  // The bus starts idle before the first frame.
  initial
  begin
    o_frame_valid = 1'b0;
    o_frame       = 16'h0000;
  end

  // Sends one frame and takes its answer in the cycle after it was accepted.
  // The word is inverted once released, so a stale frame never passes for a fresh one.
  task automatic send(input logic rd, input logic [3:0] addr, input logic [7:0] data,
                      input logic [2:0] junk, output logic [7:0] resp, output logic ok);
    ok   = 1'b0;
    resp = 8'h00;
    // A host never writes an unlisted offset, so such a request is dropped here.
    if (rd || (addr <= 4'h5))
    begin
      @(posedge i_clk);
      #1;
      o_frame_valid = 1'b1;
      o_frame       = {rd, addr, junk, data};
      @(posedge i_clk);
      #1;
      o_frame_valid = 1'b0;
      o_frame       = ~o_frame;
      ok            = (i_rdata_valid === 1'b1);
      resp          = i_rdata;
    end
  endtask
endmodule

//--- test/gate_driver_status_regs_test.sv
// Self-checking testbench of the gate driver status and control register bank.
`timescale 1ns/1ps
module gate_driver_status_regs_test;
  // ********************************************************************
  // Signals and reference model state
  // ********************************************************************
  logic                     clk;         // Bench clock, 200 MHz.
  logic                     resetn;      // Raw active-low reset.
  logic [12:0]              fv;          // Fault levels, struct order.
  gdsr_pkg::gdsr_fault_in_s faults;      // Fault levels as the design sees them.
  logic                     frame_valid; // Frame strobe from the host model.
  logic [15:0]              frame;       // Frame word from the host model.
  logic                     rdata_valid; // Answer strobe.
  logic [7:0]               rdata;       // Answer byte.
  logic [7:0]               main_c;      // Control register copies.
  logic [7:0]               drive_c;
  logic [7:0]               oc_c;
  logic [7:0]               chop_c;
  logic                     fault;       // Summary fault level.
  int                       err_count;   // Mismatches seen.
  int                       num_checks;  // Comparisons made.
  logic [31:0]              lfsr;        // Random source state.
  logic [7:0]               ctrl [2:5];  // Model of the control registers.
  logic [6:0]               fs;          // Model of summary bits 6..0.
  logic [7:0]               fet;         // Model of the per-FET byte.

  assign faults = gdsr_pkg::gdsr_fault_in_s'(fv);

  gdsr_regs i_gdsr_regs
  (
    .i_clk                             (clk),
    .i_resetn                          (resetn),
    .i_frame_valid                     (frame_valid),
    .i_frame                           (frame),
    .i_faults                          (faults),
    .o_rdata_valid                     (rdata_valid),
    .o_rdata                           (rdata),
    .o_main_control                    (main_c),
    .o_drive_strength_watchdog_control (drive_c),
    .o_overcurrent_monitor_control     (oc_c),
    .o_chopper_amp_config              (chop_c),
    .o_fault                           (fault)
  );

  gdsr_host_model i_gdsr_host_model
  (
    .i_clk         (clk),
    .i_rdata_valid (rdata_valid),
    .i_rdata       (rdata),
    .o_frame_valid (frame_valid),
    .o_frame       (frame)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Free-running clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Linear feedback shift register step.
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Expected contents of an offset; bit 7 of the summary leaves out the warning bit.
  function automatic logic [7:0] model_reg(input logic [3:0] a);
    case (a)
      4'h0:                   return {|fs[6:1], fs};
      4'h1:                   return fet;
      4'h2, 4'h3, 4'h4, 4'h5: return ctrl[a];
      default:                return 8'h00;
    endcase
  endfunction

  // Byte comparison.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Single-bit comparison.
  task automatic chk1(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  // One access; the answer is the value held before this frame's write.
  task automatic access(input logic rd, input logic [3:0] a, input logic [7:0] d);
    logic [7:0] resp;
    logic       ok;
    logic [7:0] exp;
    exp  = model_reg(a);
    lfsr = next_rand(lfsr);
    i_gdsr_host_model.send(rd, a, d, lfsr[2:0], resp, ok);
    chk1(ok, 1'b1, "answer strobe");
    chk8(resp, exp, "answer byte");
    if (!rd && (a >= 4'h2) && (a <= 4'h5))
    begin
      ctrl[a] = d;
      // A set clear bit wipes every sticky flag.
      if ((a == 4'h2) && d[0])
      begin
        fs  = 7'h00;
        fet = 8'h00;
      end
    end
  endtask

  // One-cycle fault pulse; the flags must stay after the level drops.
  task automatic pulse_faults(input logic [12:0] f);
    @(posedge clk);
    #1;
    fv = f;
    @(posedge clk);
    #1;
    fv  = 13'h0000;
    fs  = fs | {f[12], |f[7:4], |f[3:0], f[11:8]};
    fet = fet | f[7:0];
  endtask

  // Compares the control copies and the summary level one cycle later.
  task automatic check_outputs();
    @(posedge clk);
    #1;
    chk8(main_c, ctrl[2], "main control copy");
    chk8(drive_c, ctrl[3], "drive control copy");
    chk8(oc_c, ctrl[4], "monitor control copy");
    chk8(chop_c, ctrl[5], "config copy");
    chk1(fault, |fs[6:1], "fault level");
  endtask

  // Ends the run with the verdict.
  task automatic complete_run();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if ((err_count == 0) && (num_checks > 0))
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard; the whole run needs well under this many cycles.
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run();
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    fv = 13'h0000;
    resetn = 1'b0;
    err_count = 0;
    num_checks = 0;
    lfsr = 32'd94962;
    fs = 7'h00;
    fet = 8'h00;
    ctrl[2] = gdsr_pkg::RST_MAIN_CTRL;
    ctrl[3] = gdsr_pkg::RST_DRIVE_WD;
    ctrl[4] = gdsr_pkg::RST_OC_MON;
    ctrl[5] = gdsr_pkg::RST_CHOP_CFG;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    // Reset values of every offset, unlisted ones reading zero.
    for (int a = 0; a < 16; a++) access(1'b1, 4'(a), 8'h00);
    check_outputs();
    // Random writes and read-backs of the control registers.
    for (int n = 0; n < 8; n++)
    begin
      lfsr = next_rand(lfsr);
      access(1'b0, 4'(2 + n % 4), lfsr[15:8]);
      access(1'b1, 4'(2 + n % 4), 8'h00);
      check_outputs();
    end
    // Writes to the status offsets change nothing.
    pulse_faults(13'h1FFF);
    access(1'b0, 4'h0, 8'h00);
    access(1'b0, 4'h1, 8'h00);
    access(1'b1, 4'h0, 8'h00);
    access(1'b1, 4'h1, 8'h00);
    // Each fault alone, held after the level drops, then cleared.
    for (int k = 0; k < 13; k++)
    begin
      pulse_faults(13'h0001 << k);
      access(1'b1, 4'h0, 8'h00);
      access(1'b1, 4'h1, 8'h00);
      check_outputs();
      access(1'b0, 4'h2, {ctrl[2][7:1], 1'b1});
      access(1'b1, 4'h0, 8'h00);
      check_outputs();
    end
    // Random fault mixes gathered over two pulses.
    for (int n = 0; n < 8; n++)
    begin
      lfsr = next_rand(lfsr);
      pulse_faults(lfsr[12:0]);
      pulse_faults(lfsr[25:13]);
      access(1'b1, 4'h0, 8'h00);
      access(1'b1, 4'h1, 8'h00);
      check_outputs();
      access(1'b0, 4'h2, {lfsr[31:27], 3'h1});
    end
    complete_run();
  end
endmodule
